// ### rtl/cid_registers.sv
// Cache identification register bank on the coprocessor access port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Revision register returns full configured word
// - Revision register readable only when privileged
// - Cache size register readable only when privileged
// - Cache size follows current cache selector
// - No caches: cache size value reads zero
// - Top four bits flag policies, write-through zero
// - Instruction cache policy bits read 0010
// - Data cache policy bits read 0111
// - Sets, four ways, eight-word lines reported
// - No caches: cache level reads zero
// - Cache level read-only, privileged only
// - Unification and coherency points are level one
// - Levels two to seven report no cache
// - Level one type split or none
// - Cache size at opcode1 one, c0, c0, zero
// - Selector level field reads zero, ignores writes
module cid_registers
  import cid_pkg::*;
#(
  parameter logic CACHES_PRESENT = 1'b1,
  parameter cid_pkg::cid_size_t INSTR_SIZE = cid_pkg::SIZE_16KB,
  parameter cid_pkg::cid_size_t DATA_SIZE = cid_pkg::SIZE_16KB,
  parameter logic [31:0] REVISION_WORD = cid_pkg::REVISION_DEFAULT
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cpReqValid,
  input wire logic cpReqWrite,
  input wire logic [2:0] cpOpc1,
  input wire logic [3:0] cpCrn,
  input wire logic [3:0] cpCrm,
  input wire logic [2:0] cpOpc2,
  input wire logic cpPrivileged,
  input wire logic [31:0] cpWrData,
  output logic cpRespValid,
  output logic [31:0] cpRdData,
  output logic cpUndef
);
  import cid_pkg::*;

  cid_reg_t regHit;
  logic hit;
  logic allowed;
  logic instrSelect_q;
  logic instrSelect_d;
  logic [31:0] sizeWord;
  logic [31:0] levelWord;
  logic [31:0] readWord;
  logic respValid_q;
  logic [31:0] rdData_q;
  logic undef_q;
  logic readOk;

  // Decode of the access encoding
  always_comb begin
    regHit = REG_NONE;
    if (cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_IDENT,
        OPC2_REVISION)) begin
      regHit = REG_REVISION;
    end else if (cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_CACHE,
        OPC2_CACHE_SIZE)) begin
      regHit = REG_CACHE_SIZE;
    end else if (cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_CACHE,
        OPC2_CACHE_LEVEL)) begin
      regHit = REG_CACHE_LEVEL;
    end else if (cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_SELECT,
        OPC2_SELECTOR)) begin
      regHit = REG_SELECTOR;
    end
  end

  assign hit = cpReqValid && (regHit != REG_NONE);
  // Every register of this bank is closed to user mode
  assign allowed = hit && cpPrivileged;
  assign readOk = allowed && !cpReqWrite;

  // Only the instruction/data bit of the selector holds state
  always_comb begin
    instrSelect_d = instrSelect_q;
    if (allowed && cpReqWrite && (regHit == REG_SELECTOR)) begin
      instrSelect_d = cpWrData[SEL_SIDE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      instrSelect_q <= SEL_SIDE_RESET;
    end else begin
      instrSelect_q <= instrSelect_d;
    end
  end

  cid_size_word u_size_word (
    .cachesPresent(CACHES_PRESENT),
    .instrSelect(instrSelect_q),
    .instrSize(INSTR_SIZE),
    .dataSize(DATA_SIZE),
    .sizeWord(sizeWord)
  );

  // Constant per build, so no storage is spent on it
  assign levelWord = cid_level_word(CACHES_PRESENT);

  always_comb begin
    readWord = 32'h0000_0000;
    unique case (regHit)
      REG_NONE: readWord = 32'h0000_0000;
      REG_REVISION: readWord = REVISION_WORD;
      REG_CACHE_SIZE: readWord = sizeWord;
      REG_CACHE_LEVEL: readWord = levelWord;
      REG_SELECTOR: readWord[SEL_SIDE_BIT] = instrSelect_q;
    endcase
  end

  // Answer one cycle after the request; writes to read-only words are dropped
  always_ff @(posedge clock) begin
    if (srst) begin
      respValid_q <= 1'b0;
    end else begin
      respValid_q <= hit;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      undef_q <= 1'b0;
    end else begin
      undef_q <= hit && !cpPrivileged;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdData_q <= 32'h0000_0000;
    end else if (allowed && !cpReqWrite) begin
      rdData_q <= readWord;
    end else begin
      // No data leaks out on a refused or write access
      rdData_q <= 32'h0000_0000;
    end
  end

  assign cpRespValid = respValid_q;
  assign cpRdData = rdData_q;
  assign cpUndef = undef_q;

  a_unpriv_undef: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && (regHit != REG_NONE) && !cpPrivileged)
    |=> (cpUndef && cpRespValid && (cpRdData == 32'h0000_0000))
  ) else $error("unprivileged access did not raise undefined");

  a_priv_no_undef: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && cpPrivileged) |=> !cpUndef
  ) else $error("privileged access raised undefined");

  a_revision_word: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && !cpReqWrite && cpPrivileged &&
        cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_IDENT, OPC2_REVISION))
    |=> (cpRespValid && (cpRdData == REVISION_WORD))
  ) else $error("revision read returned wrong word");

  a_icache_policy: assert property (
    @(posedge clock) disable iff (srst)
    (CACHES_PRESENT && cpReqValid && !cpReqWrite && cpPrivileged &&
        instrSelect_q &&
        cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_CACHE, OPC2_CACHE_SIZE))
    |=> ((cpRdData[31:28] == 4'h2) &&
        (cpRdData[27:13] == cid_set_count(INSTR_SIZE)))
  ) else $error("instruction cache size word wrong");

  a_dcache_policy: assert property (
    @(posedge clock) disable iff (srst)
    (CACHES_PRESENT && cpReqValid && !cpReqWrite && cpPrivileged &&
        !instrSelect_q &&
        cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_CACHE, OPC2_CACHE_SIZE))
    |=> ((cpRdData[31:28] == 4'h7) &&
        (cpRdData[27:13] == cid_set_count(DATA_SIZE)))
  ) else $error("data cache size word wrong");

  a_size_geometry: assert property (
    @(posedge clock) disable iff (srst)
    (CACHES_PRESENT && cpReqValid && !cpReqWrite && cpPrivileged &&
        (regHit == REG_CACHE_SIZE))
    |=> ((cpRdData[12:3] == 10'h003) && (cpRdData[2:0] == 3'h1) &&
        !cpRdData[31])
  ) else $error("cache geometry fields wrong");

  a_level_word: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && !cpReqWrite && cpPrivileged &&
        cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_CACHE, OPC2_CACHE_LEVEL))
    |=> (cpRdData == (CACHES_PRESENT ? 32'h0920_0003 : 32'h0000_0000))
  ) else $error("cache level word wrong");

  a_selector_follow: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && cpReqWrite && cpPrivileged &&
        (regHit == REG_SELECTOR))
    ##1 (cpReqValid && !cpReqWrite && cpPrivileged &&
        (regHit == REG_SELECTOR))
    |=> (cpRdData == {31'h0000_0000, $past(cpWrData[0], 2)})
  ) else $error("selector did not keep written bit");

  a_selector_write: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && cpReqWrite && cpPrivileged &&
        cid_match(cpOpc1, cpCrn, cpCrm, cpOpc2, OPC1_SELECT, OPC2_SELECTOR))
    |=> (instrSelect_q == $past(cpWrData[0]))
  ) else $error("selector write lost");

  a_unpriv_no_write: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && !cpPrivileged) |=> $stable(instrSelect_q)
  ) else $error("unprivileged write changed selector");

  a_resp_follows: assert property (
    @(posedge clock) disable iff (srst)
    cpRespValid |-> $past(cpReqValid && (regHit != REG_NONE))
  ) else $error("response without a request");

  a_resp_on_hit: assert property (
    @(posedge clock) disable iff (srst)
    hit |=> cpRespValid
  ) else $error("mapped access got no response");

  a_miss_silent: assert property (
    @(posedge clock) disable iff (srst)
    (cpReqValid && (regHit == REG_NONE))
    |=> (!cpRespValid && !cpUndef && (cpRdData == 32'h0000_0000))
  ) else $error("unmapped access was answered");

  a_idle_quiet: assert property (
    @(posedge clock) disable iff (srst)
    !cpReqValid |=> (!cpRespValid && !cpUndef)
  ) else $error("output pulse without a request");

  a_undef_has_resp: assert property (
    @(posedge clock) disable iff (srst)
    cpUndef |-> cpRespValid
  ) else $error("undefined flag without a response");

  a_rev_unpriv: assert property (
    @(posedge clock) disable iff (srst)
    (hit && !cpPrivileged && (regHit == REG_REVISION))
    |=> (cpUndef && (cpRdData == 32'h0000_0000))
  ) else $error("user mode revision read not refused");

  a_size_unpriv: assert property (
    @(posedge clock) disable iff (srst)
    (hit && !cpPrivileged && (regHit == REG_CACHE_SIZE))
    |=> (cpUndef && (cpRdData == 32'h0000_0000))
  ) else $error("user mode cache size read not refused");

  a_level_unpriv: assert property (
    @(posedge clock) disable iff (srst)
    (hit && !cpPrivileged && (regHit == REG_CACHE_LEVEL))
    |=> (cpUndef && (cpRdData == 32'h0000_0000))
  ) else $error("user mode cache level read not refused");

  a_level_write: assert property (
    @(posedge clock) disable iff (srst)
    (allowed && cpReqWrite && (regHit == REG_CACHE_LEVEL))
    |=> (cpRespValid && !cpUndef && (cpRdData == 32'h0000_0000))
  ) else $error("cache level write not ignored");

  a_rev_write: assert property (
    @(posedge clock) disable iff (srst)
    (allowed && cpReqWrite && (regHit == REG_REVISION))
    |=> (cpRespValid && !cpUndef && (cpRdData == 32'h0000_0000))
  ) else $error("revision write not ignored");

  a_upper_none: assert property (
    @(posedge clock) disable iff (srst)
    (readOk && (regHit == REG_CACHE_LEVEL))
    |=> (cpRdData[20:3] == 18'h00000)
  ) else $error("upper cache levels not empty");

  a_l1_type: assert property (
    @(posedge clock) disable iff (srst)
    (readOk && (regHit == REG_CACHE_LEVEL))
    |=> (cpRdData[2:0] == (CACHES_PRESENT ? 3'h3 : 3'h0))
  ) else $error("level one cache type wrong");

  a_bare_level: assert property (
    @(posedge clock) disable iff (srst)
    (!CACHES_PRESENT && readOk && (regHit == REG_CACHE_LEVEL))
    |=> (cpRdData == 32'h0000_0000)
  ) else $error("cache level not zero without caches");

  a_level_points: assert property (
    @(posedge clock) disable iff (srst)
    (CACHES_PRESENT && readOk && (regHit == REG_CACHE_LEVEL))
    |=> ((cpRdData[31:30] == 2'h0) && (cpRdData[29:27] == 3'h1) &&
        (cpRdData[26:24] == 3'h1) && (cpRdData[23:21] == 3'h1))
  ) else $error("unification or coherency point wrong");

  a_sel_upper_zero: assert property (
    @(posedge clock) disable iff (srst)
    (readOk && (regHit == REG_SELECTOR))
    |=> (cpRdData[31:1] == 31'h0000_0000)
  ) else $error("selector upper bits not zero");

  a_read_alloc: assert property (
    @(posedge clock) disable iff (srst)
    (CACHES_PRESENT && readOk && (regHit == REG_CACHE_SIZE))
    |=> (cpRdData[29] && !cpRdData[31])
  ) else $error("policy flags wrong");

  a_size_follows: assert property (
    @(posedge clock) disable iff (srst)
    (CACHES_PRESENT && readOk && (regHit == REG_CACHE_SIZE))
    |=> (cpRdData[30:28] == ($past(instrSelect_q) ? 3'h2 : 3'h7))
  ) else $error("cache size did not follow selector");

  a_sel_reset: assert property (
    @(posedge clock)
    $fell(srst) |-> !instrSelect_q
  ) else $error("selector not back on data cache");

  a_quiet_no_read: assert property (
    @(posedge clock) disable iff (srst)
    !readOk |=> (cpRdData == 32'h0000_0000)
  ) else $error("data shown without a granted read");

endmodule
`default_nettype wire

// ### rtl/cid_pkg.sv
// Encodings, field layouts and fixed values of the cache identification bank
package cid_pkg;

  // Coprocessor access encodings (primary and secondary register are c0)
  localparam logic [2:0] OPC1_IDENT = 3'h0;
  localparam logic [2:0] OPC1_CACHE = 3'h1;
  localparam logic [2:0] OPC1_SELECT = 3'h2;
  localparam logic [3:0] CRN_IDENT = 4'h0;
  localparam logic [3:0] CRM_IDENT = 4'h0;
  localparam logic [2:0] OPC2_REVISION = 3'h6;
  localparam logic [2:0] OPC2_CACHE_SIZE = 3'h0;
  localparam logic [2:0] OPC2_CACHE_LEVEL = 3'h1;
  localparam logic [2:0] OPC2_SELECTOR = 3'h0;

  // Cache size word layout
  localparam int WRITE_THROUGH_BIT = 31;
  localparam int WRITE_BACK_BIT = 30;
  localparam int READ_ALLOC_BIT = 29;
  localparam int WRITE_ALLOC_BIT = 28;
  localparam int POLICY_LSB = 28;
  localparam int SETS_LSB = 13;
  localparam int WAYS_LSB = 3;
  localparam int LINE_LSB = 0;
  localparam logic [3:0] POLICY_ICACHE = 4'h2;
  localparam logic [3:0] POLICY_DCACHE = 4'h7;
  localparam logic [9:0] WAYS_FOUR = 10'h003;
  localparam logic [2:0] LINE_EIGHT_WORDS = 3'h1;
  localparam logic [14:0] SETS_4KB = 15'h001f;
  localparam logic [14:0] SETS_8KB = 15'h003f;
  localparam logic [14:0] SETS_16KB = 15'h007f;
  localparam logic [14:0] SETS_32KB = 15'h00ff;
  localparam logic [14:0] SETS_64KB = 15'h01ff;

  // Cache level word layout
  localparam int UNIF_LSB = 27;
  localparam int COHER_LSB = 24;
  localparam int INNER_UNIF_LSB = 21;
  localparam int UPPER_TYPES_LSB = 3;
  localparam int L1_TYPE_LSB = 0;
  localparam logic [2:0] LEVEL_ONE = 3'h1;
  localparam logic [2:0] TYPE_NONE = 3'h0;
  localparam logic [2:0] TYPE_SPLIT = 3'h3;
  localparam logic [17:0] UPPER_TYPES_NONE = 18'h00000;

  // Cache selector layout and reset
  localparam int SEL_SIDE_BIT = 0;
  localparam logic SEL_SIDE_RESET = 1'b0;
  localparam logic SEL_SIDE_INSTR = 1'b1;

  // Implementation revision word, value arbitrary
  localparam logic [31:0] REVISION_DEFAULT = 32'h0000_0000;

  typedef enum logic [2:0] {
    SIZE_4KB = 3'b000,
    SIZE_8KB = 3'b001,
    SIZE_16KB = 3'b010,
    SIZE_32KB = 3'b011,
    SIZE_64KB = 3'b100
  } cid_size_t;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_REVISION = 3'b001,
    REG_CACHE_SIZE = 3'b010,
    REG_CACHE_LEVEL = 3'b011,
    REG_SELECTOR = 3'b100
  } cid_reg_t;

  function automatic logic [14:0] cid_set_count(input cid_size_t size);
    case (size)
      SIZE_4KB: cid_set_count = SETS_4KB;
      SIZE_8KB: cid_set_count = SETS_8KB;
      SIZE_16KB: cid_set_count = SETS_16KB;
      SIZE_32KB: cid_set_count = SETS_32KB;
      default: cid_set_count = SETS_64KB;
    endcase
  endfunction

  function automatic logic cid_match(input logic [2:0] opc1,
      input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] opc2,
      input logic [2:0] wantOpc1, input logic [2:0] wantOpc2);
    cid_match = (opc1 == wantOpc1) && (crn == CRN_IDENT) &&
        (crm == CRM_IDENT) && (opc2 == wantOpc2);
  endfunction

  function automatic logic [31:0] cid_level_word(input logic present);
    cid_level_word = 32'h0000_0000;
    if (present) begin
      cid_level_word[UNIF_LSB +: 3] = LEVEL_ONE;
      cid_level_word[COHER_LSB +: 3] = LEVEL_ONE;
      cid_level_word[INNER_UNIF_LSB +: 3] = LEVEL_ONE;
      cid_level_word[UPPER_TYPES_LSB +: 18] = UPPER_TYPES_NONE;
      cid_level_word[L1_TYPE_LSB +: 3] = TYPE_SPLIT;
    end
  endfunction

endpackage

// ### rtl/cid_size_word.sv
// Cache size word for the cache picked by the selector
`timescale 1ns/1ps
`default_nettype none
module cid_size_word
  import cid_pkg::*;
(
  input wire logic cachesPresent,
  input wire logic instrSelect,
  input wire cid_pkg::cid_size_t instrSize,
  input wire cid_pkg::cid_size_t dataSize,
  output logic [31:0] sizeWord
);
  always_comb begin
    sizeWord = 32'h0000_0000;
    // Left at zero without caches; software must not trust it
    if (cachesPresent) begin
      if (instrSelect) begin
        sizeWord[POLICY_LSB +: 4] = POLICY_ICACHE;
        sizeWord[SETS_LSB +: 15] = cid_set_count(instrSize);
      end else begin
        sizeWord[POLICY_LSB +: 4] = POLICY_DCACHE;
        sizeWord[SETS_LSB +: 15] = cid_set_count(dataSize);
      end
      sizeWord[WRITE_THROUGH_BIT] = 1'b0;
      sizeWord[WAYS_LSB +: 10] = WAYS_FOUR;
      sizeWord[LINE_LSB +: 3] = LINE_EIGHT_WORDS;
    end
  end
endmodule
`default_nettype wire

// ### dv/cid_registers_tb.sv
// Self-checking bench for the cache identification register bank
`timescale 1ns/1ps
`default_nettype none
module cid_registers_tb;
  import cid_pkg::*;
  // Revision word, value arbitrary
  localparam logic [31:0] REV = 32'h1357_9bdf;
  // Data 32KB, instruction 8KB, so a wrong pick shows in the set count
  localparam logic [31:0] D_WORD = {4'h7, 15'h00ff, 10'h003, 3'h1};
  localparam logic [31:0] I_WORD = {4'h2, 15'h003f, 10'h003, 3'h1};
  localparam logic [31:0] L_WORD = {2'h0, 3'h1, 3'h1, 3'h1, 18'h0, 3'h3};
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cpReqValid = 1'b0;
  logic cpReqWrite = 1'b0;
  logic [2:0] cpOpc1 = 3'h0;
  logic [3:0] cpCrn = 4'h0;
  logic [3:0] cpCrm = 4'h0;
  logic [2:0] cpOpc2 = 3'h0;
  logic cpPrivileged = 1'b0;
  logic [31:0] cpWrData = 32'h0;
  logic cpRespValid, cpUndef, bareResp, bareUndef;
  logic [31:0] cpRdData, bareData;
  int n_errors = 0;
  int tests_run = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  cid_registers #(.CACHES_PRESENT(1'b1), .INSTR_SIZE(SIZE_8KB),
      .DATA_SIZE(SIZE_32KB), .REVISION_WORD(REV)) DUT (
    .clock(clock), .srst(srst), .cpReqValid(cpReqValid),
    .cpReqWrite(cpReqWrite), .cpOpc1(cpOpc1), .cpCrn(cpCrn), .cpCrm(cpCrm),
    .cpOpc2(cpOpc2), .cpPrivileged(cpPrivileged), .cpWrData(cpWrData),
    .cpRespValid(cpRespValid), .cpRdData(cpRdData), .cpUndef(cpUndef));

  // Build without caches shares the request lines
  cid_registers #(.CACHES_PRESENT(1'b0), .REVISION_WORD(REV)) dutBare (
    .clock(clock), .srst(srst), .cpReqValid(cpReqValid),
    .cpReqWrite(cpReqWrite), .cpOpc1(cpOpc1), .cpCrn(cpCrn), .cpCrm(cpCrm),
    .cpOpc2(cpOpc2), .cpPrivileged(cpPrivileged), .cpWrData(cpWrData),
    .cpRespValid(bareResp), .cpRdData(bareData), .cpUndef(bareUndef));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request stays up between calls, so back-to-back calls are one burst
  task automatic xfer(input logic wr, input logic [2:0] o1,
      input logic [2:0] o2, input logic pv, input logic [31:0] wd,
      input logic er, input logic eu, input logic [31:0] ed);
    cpReqValid = 1'b1;
    cpReqWrite = wr;
    cpOpc1 = o1;
    cpOpc2 = o2;
    cpPrivileged = pv;
    cpWrData = wd;
    @(negedge clock);
    check({31'h0, cpRespValid}, {31'h0, er});
    check({31'h0, cpUndef}, {31'h0, eu});
    check(cpRdData, ed);
  endtask

  task automatic idle();
    cpReqValid = 1'b0;
    @(negedge clock);
    check({31'h0, cpRespValid}, 32'h0);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clock);
    n_errors++;
    $display("CHECK FAILED t=%0t run did not end", $time);
    complete_run();
  end

  initial begin
    repeat (6) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    check({cpRdData[31:2], cpRespValid, cpUndef}, 32'h0);
    xfer(1'b0, OPC1_IDENT, OPC2_REVISION, 1'b1, 32'h0, 1'b1, 1'b0, REV);
    xfer(1'b0, OPC1_IDENT, OPC2_REVISION, 1'b0, 32'h0, 1'b1, 1'b1, 32'h0);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b1, 1'b0, D_WORD);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b0, 32'h0, 1'b1, 1'b1, 32'h0);
    // Level field bits set too: they must be dropped
    xfer(1'b1, OPC1_SELECT, OPC2_SELECTOR, 1'b1, 32'hffff_ffff, 1'b1, 1'b0, 32'h0);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b1, 1'b0, I_WORD);
    xfer(1'b0, OPC1_SELECT, OPC2_SELECTOR, 1'b1, 32'h0, 1'b1, 1'b0, 32'h1);
    // Unprivileged write must leave the selection alone
    xfer(1'b1, OPC1_SELECT, OPC2_SELECTOR, 1'b0, 32'h0, 1'b1, 1'b1, 32'h0);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b1, 1'b0, I_WORD);
    xfer(1'b1, OPC1_SELECT, OPC2_SELECTOR, 1'b1, 32'h0, 1'b1, 1'b0, 32'h0);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b1, 1'b0, D_WORD);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_LEVEL, 1'b1, 32'h0, 1'b1, 1'b0, L_WORD);
    check(bareData, 32'h0);
    check({31'h0, bareResp}, 32'h1);
    check({31'h0, bareUndef}, 32'h0);
    xfer(1'b1, OPC1_CACHE, OPC2_CACHE_LEVEL, 1'b1, 32'hffff_ffff, 1'b1, 1'b0, 32'h0);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_LEVEL, 1'b1, 32'h0, 1'b1, 1'b0, L_WORD);
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_LEVEL, 1'b0, 32'h0, 1'b1, 1'b1, 32'h0);
    // Encodings outside the bank get no answer at all
    cpCrn = 4'h1;
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b0, 1'b0, 32'h0);
    cpCrn = 4'h0;
    cpCrm = 4'h1;
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b0, 1'b0, 32'h0);
    cpCrm = 4'h0;
    xfer(1'b0, OPC1_CACHE, 3'h7, 1'b1, 32'h0, 1'b0, 1'b0, 32'h0);
    xfer(1'b0, 3'h3, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b0, 1'b0, 32'h0);
    // Leave the instruction cache picked so the reset below must undo it
    xfer(1'b1, OPC1_SELECT, OPC2_SELECTOR, 1'b1, 32'h1, 1'b1, 1'b0, 32'h0);
    idle();
    // Reset in mid-run puts the selector back on the data cache
    srst = 1'b1;
    @(negedge clock);
    srst = 1'b0;
    xfer(1'b0, OPC1_CACHE, OPC2_CACHE_SIZE, 1'b1, 32'h0, 1'b1, 1'b0, D_WORD);
    idle();
    complete_run();
  end
endmodule
`default_nettype wire
